// ---- include/ifeb_regs.vh ----
// Register indices, implemented-bit masks and reset values of the interrupt flag bank
`ifndef IFEB_REGS_VH
`define IFEB_REGS_VH

// Register indices on the plain register port
`define IFEB_IDX_FLAGS_0   3'h0
`define IFEB_IDX_FLAGS_1   3'h1
`define IFEB_IDX_FLAGS_2   3'h2
`define IFEB_IDX_FLAGS_3   3'h3
`define IFEB_IDX_FLAGS_4   3'h4
`define IFEB_IDX_ENABLES_0 3'h5
`define IFEB_NUM_REGS      6

// Implemented bits in each register; everything else reads zero
`define IFEB_MASK_FLAGS_0   16'h7fff
`define IFEB_MASK_FLAGS_1   16'hffdf
`define IFEB_MASK_FLAGS_2   16'h601f
`define IFEB_MASK_FLAGS_3   16'he600
`define IFEB_MASK_FLAGS_4   16'hce7e
`define IFEB_MASK_ENABLES_0 16'h7fff

// Variant-dependent source bits
`define IFEB_CAN_MASK_2     16'h000c
`define IFEB_CAN_MASK_4     16'h0040
`define IFEB_DAC_MASK_4     16'hc000

// Flag register 0 field positions
`define IFEB_BIT_CMP1   2
`define IFEB_BIT_CAP1   1
`define IFEB_BIT_EXT0   0

`define IFEB_RST_VALUE  16'h0000

`endif

// ---- src/ifeb_flag_reg.v ----
// One 16-bit flag or enable register with hardware set and software write
`timescale 1ns/1ps
`include "ifeb_regs.vh"
module ifeb_flag_reg
#(
   parameter [15:0] IMPL_MASK = 16'hffff
)
(
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_wr,
   input wire [15:0] i_wdata,
   input wire [15:0] i_set,
   output wire [15:0] o_value
);

   reg [15:0] value_ff;
   reg [15:0] nxt_value;

   // Hardware set wins over a software write in the same cycle, so no event is lost
   always @*
   begin
      nxt_value = value_ff;
      if (i_wr)
      begin
         nxt_value = i_wdata;
      end
      nxt_value = (nxt_value | i_set) & IMPL_MASK;
   end

   // Power-on state is all zero
   always @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         value_ff <= `IFEB_RST_VALUE;
      end
      else
      begin
         value_ff <= nxt_value;
      end
   end

   assign o_value = value_ff;

endmodule

// ---- src/ifeb_bank.v ----
// Interrupt flag and enable register bank with pending request outputs
//
// Function
// - A flag bit reads one after its source requested, zero otherwise.
// - An enable bit set allows its source request; cleared blocks it.
// - Unimplemented bits read zero and ignore writes.
// - Implemented flag and enable bits are read/write and reset to zero.
// - Without the CAN controller, CAN event, receive and transmit sources never request.
// - Without the audio converter, left and right channel sources never request.
// - Flag register 0: compare 1 at bit 2, capture 1 bit 1, external 0 bit 0.
// - Flag register 1 upper byte holds serial2, external 2, timers, compares, transfer 2.
// - Flag register 1 lower byte holds captures 8/7, external 1, change, comparator, I2C.
// - Flag register 2 holds transfers 4/3, parallel port, CAN, SPI2; bits 12-5 unused.
// - Flag register 3 holds PWM1 fault, alarm, transfer 5, encoder 1, PWM1 error.
// - Flag register 4 holds DAC, encoder 2, PWM2, CAN transmit, transfers, checksum, errors.
// - Enable register 0 upper byte holds transfer 1, ADC, serial1, SPI1, timer 3.
// - Enable register 0 lower byte holds timer 2 down to external interrupt 0.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "ifeb_regs.vh"
module ifeb_bank
#(
   parameter HAS_CAN = 1,
   parameter HAS_DAC = 1
)
(
   input wire i_ref_clk,
   input wire i_rst,
   input wire [2:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [15:0] i_evt_0,
   input wire [15:0] i_evt_1,
   input wire [15:0] i_evt_2,
   input wire [15:0] i_evt_3,
   input wire [15:0] i_evt_4,
   output reg [15:0] o_rdata,
   output reg [14:0] o_pend_0,
   output reg [79:0] o_flags
);

   // Variant masks strip sources whose peripheral is absent
   localparam [15:0] CAN_OFF_2 = (HAS_CAN != 0) ? 16'h0000 : `IFEB_CAN_MASK_2;
   localparam [15:0] CAN_OFF_4 = (HAS_CAN != 0) ? 16'h0000 : `IFEB_CAN_MASK_4;
   localparam [15:0] DAC_OFF_4 = (HAS_DAC != 0) ? 16'h0000 : `IFEB_DAC_MASK_4;
   localparam [15:0] MASK_2 = `IFEB_MASK_FLAGS_2 & ~CAN_OFF_2;
   localparam [15:0] MASK_4 = `IFEB_MASK_FLAGS_4 & ~(CAN_OFF_4 | DAC_OFF_4);

   wire [15:0] flags_0;
   wire [15:0] flags_1;
   wire [15:0] flags_2;
   wire [15:0] flags_3;
   wire [15:0] flags_4;
   wire [15:0] enables_0;
   wire [5:0] wr_sel;
   reg [15:0] nxt_rdata;
   wire [15:0] set_0;
   wire [15:0] set_1;
   wire [15:0] set_2;
   wire [15:0] set_3;
   wire [15:0] set_4;
   wire [14:0] en_0;

   // Variant switches as single bits, used to gate absent sources at their input
   localparam [0:0] CAN_ON = (HAS_CAN != 0) ? 1'b1 : 1'b0;
   localparam [0:0] DAC_ON = (HAS_DAC != 0) ? 1'b1 : 1'b0;

   // Flag register 0 sources, one named line per request
   wire xfer1_done_set = i_evt_0[14];
   wire adc_done_set = i_evt_0[13];
   wire serial1_tx_set = i_evt_0[12];
   wire serial1_rx_set = i_evt_0[11];
   wire spi1_event_set = i_evt_0[10];
   wire spi1_error_set = i_evt_0[9];
   wire tmr3_req_set = i_evt_0[8];
   wire tmr2_req_set = i_evt_0[7];
   wire cmp2_req_set = i_evt_0[6];
   wire cap2_req_set = i_evt_0[5];
   wire xfer0_done_set = i_evt_0[4];
   wire tmr1_req_set = i_evt_0[3];
   wire cmp1_req_set = i_evt_0[`IFEB_BIT_CMP1];
   wire cap1_req_set = i_evt_0[`IFEB_BIT_CAP1];
   wire ext0_req_set = i_evt_0[`IFEB_BIT_EXT0];

   // Holes are tied low here as well as masked in the register, so a stray line cannot set them
   assign set_0 =
   {
      1'h0,
      xfer1_done_set,
      adc_done_set,
      serial1_tx_set,
      serial1_rx_set,
      spi1_event_set,
      spi1_error_set,
      tmr3_req_set,
      tmr2_req_set,
      cmp2_req_set,
      cap2_req_set,
      xfer0_done_set,
      tmr1_req_set,
      cmp1_req_set,
      cap1_req_set,
      ext0_req_set
   };

   // Flag register 1 sources
   wire serial2_tx_set = i_evt_1[15];
   wire serial2_rx_set = i_evt_1[14];
   wire ext2_req_set = i_evt_1[13];
   wire tmr5_req_set = i_evt_1[12];
   wire tmr4_req_set = i_evt_1[11];
   wire cmp4_req_set = i_evt_1[10];
   wire cmp3_req_set = i_evt_1[9];
   wire xfer2_done_set = i_evt_1[8];
   wire cap8_req_set = i_evt_1[7];
   wire cap7_req_set = i_evt_1[6];
   wire ext1_req_set = i_evt_1[4];
   wire pin_change_set = i_evt_1[3];
   wire comparator_set = i_evt_1[2];
   wire i2c_master_set = i_evt_1[1];
   wire i2c_slave_set = i_evt_1[0];

   // Bit 5 has no source
   assign set_1 =
   {
      serial2_tx_set,
      serial2_rx_set,
      ext2_req_set,
      tmr5_req_set,
      tmr4_req_set,
      cmp4_req_set,
      cmp3_req_set,
      xfer2_done_set,
      cap8_req_set,
      cap7_req_set,
      1'h0,
      ext1_req_set,
      pin_change_set,
      comparator_set,
      i2c_master_set,
      i2c_slave_set
   };

   // Flag register 2 sources; the CAN lines are cut when the controller is absent
   wire xfer4_done_set = i_evt_2[14];
   wire par_port_set = i_evt_2[13];
   wire xfer3_done_set = i_evt_2[4];
   wire can_event_set = CAN_ON & i_evt_2[3];
   wire can_rx_ready_set = CAN_ON & i_evt_2[2];
   wire spi2_event_set = i_evt_2[1];
   wire spi2_error_set = i_evt_2[0];

   assign set_2 =
   {
      1'h0,
      xfer4_done_set,
      par_port_set,
      8'h00,
      xfer3_done_set,
      can_event_set,
      can_rx_ready_set,
      spi2_event_set,
      spi2_error_set
   };

   // Flag register 3 sources; the low byte and bit 8 have none
   wire pwm1_fault_set = i_evt_3[15];
   wire calendar_alarm_set = i_evt_3[14];
   wire xfer5_done_set = i_evt_3[13];
   wire encoder1_set = i_evt_3[10];
   wire pwm1_error_set = i_evt_3[9];

   assign set_3 =
   {
      pwm1_fault_set,
      calendar_alarm_set,
      xfer5_done_set,
      2'h0,
      encoder1_set,
      pwm1_error_set,
      9'h000
   };

   // Flag register 4 sources; DAC and CAN transmit lines depend on the variant
   wire dac_left_set = DAC_ON & i_evt_4[15];
   wire dac_right_set = DAC_ON & i_evt_4[14];
   wire encoder2_set = i_evt_4[11];
   wire pwm2_fault_set = i_evt_4[10];
   wire pwm2_error_set = i_evt_4[9];
   wire can_tx_request_set = CAN_ON & i_evt_4[6];
   wire xfer7_done_set = i_evt_4[5];
   wire xfer6_done_set = i_evt_4[4];
   wire checksum_gen_set = i_evt_4[3];
   wire serial2_error_set = i_evt_4[2];
   wire serial1_error_set = i_evt_4[1];

   assign set_4 =
   {
      dac_left_set,
      dac_right_set,
      2'h0,
      encoder2_set,
      pwm2_fault_set,
      pwm2_error_set,
      2'h0,
      can_tx_request_set,
      xfer7_done_set,
      xfer6_done_set,
      checksum_gen_set,
      serial2_error_set,
      serial1_error_set,
      1'h0
   };

   // Named enable bits of register 0; bit 15 is a hole and never gates anything
   wire xfer1_done_en = enables_0[14];
   wire adc_done_en = enables_0[13];
   wire serial1_tx_en = enables_0[12];
   wire serial1_rx_en = enables_0[11];
   wire spi1_event_en = enables_0[10];
   wire spi1_error_en = enables_0[9];
   wire tmr3_req_en = enables_0[8];
   wire tmr2_req_en = enables_0[7];
   wire cmp2_req_en = enables_0[6];
   wire cap2_req_en = enables_0[5];
   wire xfer0_done_en = enables_0[4];
   wire tmr1_req_en = enables_0[3];
   wire cmp1_req_en = enables_0[2];
   wire cap1_req_en = enables_0[1];
   wire ext0_req_en = enables_0[0];

   assign en_0 =
   {
      xfer1_done_en,
      adc_done_en,
      serial1_tx_en,
      serial1_rx_en,
      spi1_event_en,
      spi1_error_en,
      tmr3_req_en,
      tmr2_req_en,
      cmp2_req_en,
      cap2_req_en,
      xfer0_done_en,
      tmr1_req_en,
      cmp1_req_en,
      cap1_req_en,
      ext0_req_en
   };

   // One write strobe per register, decoded from the index
   genvar gi;
   generate
      for (gi = 0; gi < `IFEB_NUM_REGS; gi = gi + 1)
      begin : g_sel
         localparam [2:0] IDX = gi;
         assign wr_sel[gi] = i_wr && (i_addr == IDX);
      end
   endgenerate

   // Flag register 0; bits 2..0 are compare 1, capture 1, external 0
   ifeb_flag_reg #(.IMPL_MASK(`IFEB_MASK_FLAGS_0)) u_flags_0
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr(wr_sel[`IFEB_IDX_FLAGS_0]),
      .i_wdata(i_wdata),
      .i_set(set_0),
      .o_value(flags_0)
   );

   // Flag register 1; bit 5 is the only hole
   ifeb_flag_reg #(.IMPL_MASK(`IFEB_MASK_FLAGS_1)) u_flags_1
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr(wr_sel[`IFEB_IDX_FLAGS_1]),
      .i_wdata(i_wdata),
      .i_set(set_1),
      .o_value(flags_1)
   );

   // Flag register 2; CAN bits vanish on variants without the controller
   ifeb_flag_reg #(.IMPL_MASK(MASK_2)) u_flags_2
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr(wr_sel[`IFEB_IDX_FLAGS_2]),
      .i_wdata(i_wdata),
      .i_set(set_2),
      .o_value(flags_2)
   );

   // Flag register 3; only the upper byte has sources
   ifeb_flag_reg #(.IMPL_MASK(`IFEB_MASK_FLAGS_3)) u_flags_3
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr(wr_sel[`IFEB_IDX_FLAGS_3]),
      .i_wdata(i_wdata),
      .i_set(set_3),
      .o_value(flags_3)
   );

   // Flag register 4; DAC and CAN transmit bits depend on the variant
   ifeb_flag_reg #(.IMPL_MASK(MASK_4)) u_flags_4
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr(wr_sel[`IFEB_IDX_FLAGS_4]),
      .i_wdata(i_wdata),
      .i_set(set_4),
      .o_value(flags_4)
   );

   // Enable register 0 is written by software only
   ifeb_flag_reg #(.IMPL_MASK(`IFEB_MASK_ENABLES_0)) u_enables_0
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr(wr_sel[`IFEB_IDX_ENABLES_0]),
      .i_wdata(i_wdata),
      .i_set(16'h0000),
      .o_value(enables_0)
   );

   // Read mux; unmapped indices read zero
   always @*
   begin
      nxt_rdata = 16'h0000;
      if (i_rd)
      begin
         case (i_addr)
            `IFEB_IDX_FLAGS_0: nxt_rdata = flags_0;
            `IFEB_IDX_FLAGS_1: nxt_rdata = flags_1;
            `IFEB_IDX_FLAGS_2: nxt_rdata = flags_2;
            `IFEB_IDX_FLAGS_3: nxt_rdata = flags_3;
            `IFEB_IDX_FLAGS_4: nxt_rdata = flags_4;
            `IFEB_IDX_ENABLES_0: nxt_rdata = enables_0;
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end

   // Outputs registered; pending and flag views trail the registers by one cycle
   always @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_rdata <= 16'h0000;
         o_pend_0 <= 15'h0000;
         o_flags <= 80'h0;
      end
      else
      begin
         o_rdata <= nxt_rdata;
         o_pend_0 <= flags_0[14:0] & en_0;
         o_flags <= {flags_4, flags_3, flags_2, flags_1, flags_0};
      end
   end

endmodule

// ---- tb/ifeb_checker.sv ----
// Port assertions for the interrupt flag bank
`timescale 1ns/1ps
module ifeb_checker (
   input wire i_ref_clk, input wire i_rst, input wire [2:0] i_addr,
   input wire [15:0] i_wdata, input wire i_wr, input wire i_rd, input wire [15:0] i_evt_0,
   input wire [15:0] o_rdata, input wire [14:0] o_pend_0, input wire [79:0] o_flags
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   a_evt_sets_flag: assert property (i_evt_0[0] |=> ##1 o_flags[0])
      else $error("event lost");
   a_flag_holds: assert property ($fell(o_flags[0]) |-> $past(i_wr, 2) && $past(i_addr, 2) == 3'h0)
      else $error("flag fell");
   a_write_clears: assert property (i_wr && i_addr == 3'h0 && !i_wdata[1] && !i_evt_0[1]
      |=> ##1 !o_flags[1])
      else $error("no clear");
   a_unimpl_zero: assert property ((o_flags & ~80'hce7ee600601fffdf7fff) == 80'h0)
      else $error("bad bit");
   a_unmapped_read: assert property (i_rd && i_addr > 3'h5 |=> o_rdata == 16'h0)
      else $error("unmapped");
   a_read_matches: assert property (i_rd && i_addr < 3'h5
      |=> o_rdata == o_flags[$past(i_addr) * 16 +: 16])
      else $error("read");
   a_pend_needs_flag: assert property ((o_pend_0 & ~o_flags[14:0]) == 15'h0)
      else $error("pend");
   a_enable_blocks: assert property (i_wr && i_addr == 3'h5 && !i_wdata[0]
      |=> ##1 !o_pend_0[0])
      else $error("masked");
endmodule
bind ifeb_bank ifeb_checker i_chk (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
   .i_evt_0, .o_rdata, .o_pend_0, .o_flags);

// ---- tb/ifeb_src_model.sv ----
// Peripheral event sources feeding set pulses into the bank
`timescale 1ns/1ps
module ifeb_src_model (
   input wire [79:0] i_req,
   output wire [15:0] o_evt_0, output wire [15:0] o_evt_1, output wire [15:0] o_evt_2,
   output wire [15:0] o_evt_3, output wire [15:0] o_evt_4
);
   // Each source drives its own line only for the cycle it asks
   assign {o_evt_4, o_evt_3, o_evt_2, o_evt_1, o_evt_0} = i_req;
endmodule

// ---- tb/ifeb_bank_tb.sv ----
// Self-checking bench for the interrupt flag bank
`timescale 1ns/1ps
module ifeb_bank_tb;
   reg i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
   reg [2:0] i_addr = 0;
   reg [15:0] i_wdata = 0, lf = 16'h001c, old, ev;
   reg [79:0] req = 0;
   wire [15:0] e0, e1, e2, e3, e4, o_rdata;
   wire [14:0] o_pend_0;
   wire [79:0] o_flags;
   integer n_fail = 0, n_tests = 0, cyc = 0, i;
   reg [15:0] mk [0:7] = '{16'h7fff, 16'hffdf, 16'h601f, 16'he600, 16'hce7e, 16'h7fff, 0, 0};
   reg [15:0] ex [0:7] = '{default: 16'h0};
   reg [15:0] mv [0:7] = '{16'h7fff, 16'hffdf, 16'h6013, 16'he600, 16'h0e3e, 16'h7fff, 0, 0};
   wire [15:0] o_rdata_nv;
   wire [14:0] o_pend_nv;
   wire [79:0] o_flags_nv;
   always #20 i_ref_clk = ~i_ref_clk;
   ifeb_src_model i_ifeb_src_model (.i_req(req), .o_evt_0(e0), .o_evt_1(e1), .o_evt_2(e2),
      .o_evt_3(e3), .o_evt_4(e4));
   ifeb_bank i_ifeb_bank (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_evt_0(e0),
      .i_evt_1(e1), .i_evt_2(e2), .i_evt_3(e3), .i_evt_4(e4), .o_rdata, .o_pend_0, .o_flags);
   // Variant without the CAN controller and the audio converter
   ifeb_bank #(.HAS_CAN(0), .HAS_DAC(0)) i_ifeb_bank_nv (.i_ref_clk, .i_rst, .i_addr, .i_wdata,
      .i_wr, .i_rd, .i_evt_0(e0), .i_evt_1(e1), .i_evt_2(e2), .i_evt_3(e3), .i_evt_4(e4),
      .o_rdata(o_rdata_nv), .o_pend_0(o_pend_nv), .o_flags(o_flags_nv));
   function [15:0] lfsr_next(input [15:0] x);
      lfsr_next = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task chk(input string nm, input [15:0] x, input [15:0] y);
      begin
         n_tests = n_tests + 1;
         if (x !== y)
         begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s exp %h got %h", nm, x, y);
         end
      end
   endtask
   // One bus cycle; an event may hit the same edge as a write, and then wins
   task op(input [2:0] a, input w, input r, input [15:0] d, input [15:0] e);
      begin
         @(posedge i_ref_clk);
         ev = (a < 5) ? e : 16'h0;
         i_addr <= a;
         i_wdata <= d;
         i_wr <= w;
         i_rd <= r;
         req <= {64'h0, ev} << (a * 16);
         @(posedge i_ref_clk);
         i_wr <= 0;
         i_rd <= 0;
         req <= 0;
         old = ex[a];
         ex[a] = ((w ? d : old) | ev) & mk[a];
         #1;
         if (r) chk("rdata", old, o_rdata);
         if (r) chk("rdata_nv", old & mv[a], o_rdata_nv);
      end
   endtask
   // Outputs lag the registers, so let two edges pass
   task cmp;
      begin
         repeat (2) @(posedge i_ref_clk);
         #1;
         for (i = 0; i < 5; i = i + 1) chk("flags", ex[i], o_flags[i * 16 +: 16]);
         chk("pend", {1'b0, ex[0][14:0] & ex[5][14:0]}, {1'b0, o_pend_0});
         for (i = 0; i < 5; i = i + 1)
            chk("flags_nv", ex[i] & mv[i], o_flags_nv[i * 16 +: 16]);
         chk("pend_nv", {1'b0, ex[0][14:0] & ex[5][14:0]}, {1'b0, o_pend_nv});
      end
   endtask
   task close_out;
      begin
         $display("tests %0d failures %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // Cuts a hang short
   always @(posedge i_ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         n_fail = n_fail + 1;
         close_out;
      end
   end
   initial
   begin
      repeat (4) @(posedge i_ref_clk);
      i_rst <= 0;
      cmp;
      for (int a = 0; a < 8; a++) op(a, 0, 1, 0, 0);
      for (int a = 0; a < 8; a++) op(a, 1, 0, 16'hffff, 0);
      for (int a = 0; a < 8; a++) op(a, 0, 1, 0, 0);
      cmp;
      op(0, 1, 0, 0, 16'h0005);
      op(5, 1, 0, 16'h0004, 0);
      cmp;
      op(2, 0, 0, 0, 16'h000c);
      op(4, 0, 0, 0, 16'hc040);
      cmp;
      // Random traffic, unmapped indices included
      repeat (150)
      begin
         lf = lfsr_next(lf);
         old = lfsr_next(lf);
         op(lf[2:0], lf[3], lf[4] & ~lf[3], old, lf & {old[7:0], old[15:8]});
         cmp;
      end
      close_out;
   end
endmodule
